// *** bench/smbtg_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbtg_chk #(
  parameter int TIMEOUT_CYC = 3000,
  parameter int STRETCH_CYC = 2000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic devSclO,
  input wire logic devSclOeB,
  input wire logic devSdaO,
  input wire logic devSdaOeB,
  input wire logic hostSclO,
  input wire logic hostSclOeB,
  input wire logic hostSdaO,
  input wire logic hostSdaOeB,
  input wire logic scl,
  input wire logic sda
);
  logic [21:0] lowCnt_r, lowCnt_nxt, stCnt_r, stCnt_nxt, hLow_r, hLow_nxt;
  logic [7:0]  gap_r, gap_nxt;
  logic        sdaQ_r, inMsg_r, inMsg_nxt, startEv, stopEv;
  always_comb begin
    startEv    = scl & sdaQ_r & ~sda;
    stopEv     = scl & ~sdaQ_r & sda;
    lowCnt_nxt = scl ? 22'h0 : lowCnt_r + 22'h1;
    stCnt_nxt  = (startEv | stopEv) ? 22'h0 : stCnt_r + {21'h0, ~devSclOeB};
    hLow_nxt   = hostSclOeB ? 22'h0 : hLow_r + 22'h1;
    gap_nxt    = stopEv ? 8'h0 : gap_r + {7'h0, gap_r != 8'hFF};
    inMsg_nxt  = startEv | (inMsg_r & ~stopEv);
  end
  // Gap counter starts saturated so the first start after reset is legal
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lowCnt_r <= 22'h0;
      stCnt_r  <= 22'h0;
      hLow_r   <= 22'h0;
      gap_r    <= 8'hFF;
      inMsg_r  <= 1'b0;
      sdaQ_r   <= 1'b1;
    end else begin
      lowCnt_r <= lowCnt_nxt;
      stCnt_r  <= stCnt_nxt;
      hLow_r   <= hLow_nxt;
      gap_r    <= gap_nxt;
      inMsg_r  <= inMsg_nxt;
      sdaQ_r   <= sda;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_low_bound: assert property (lowCnt_r <= TIMEOUT_CYC + 8)
    else $error("clock line held low past the timeout");
  chk_stretch_cap: assert property (stCnt_r <= STRETCH_CYC + 4)
    else $error("target stretch exceeded its limit");
  chk_abort_release: assert property (stCnt_r >= STRETCH_CYC |-> ##[0:6] (devSclOeB && devSdaOeB))
    else $error("target kept the lines after stretch limit");
  chk_drive_start: assert property ($fell(devSdaOeB) |-> $past(!scl) && inMsg_r)
    else $error("target drove data outside a message or with clock high");
  chk_drive_hold: assert property ($fell(devSdaOeB) |=> !devSdaOeB [*8])
    else $error("target data drive not held");
  chk_host_low_min: assert property ($rose(hostSclOeB) |-> hLow_r >= 62)
    else $error("host clock low phase too short");
  chk_host_low_max: assert property (hLow_r <= 2500)
    else $error("host clock low phase too long");
  chk_idle_gap: assert property (startEv |-> gap_r >= 65)
    else $error("start too soon after stop");
  chk_drive_zero: assert property (!devSclO && !devSdaO && !hostSclO && !hostSdaO)
    else $error("a line driver output was not low");
  cover property (startEv);
  cover property ($fell(devSdaOeB));
  cover property (stCnt_r >= STRETCH_CYC);
endmodule : smbtg_chk
`default_nettype wire

// *** bench/smbus_target_addr_timeout_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin errorCnt++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module smbus_target_addr_timeout_test;
  localparam int TO = 3000;
  localparam int ST = 2000;
  localparam logic [6:0] EXP [27] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47,
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h53, 7'h53, 7'h53, 7'h53,
    7'h54, 7'h56, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5A};
  logic       sys_clk = 1'b0, rst_b = 1'b0, txValid = 1'b0, cmdValid = 1'b0, cmdRead = 1'b0;
  logic [1:0] p0 = 2'h0, p1 = 2'h0, p2 = 2'h0;
  logic [7:0] txData = 8'h00, cmdData = 8'h00, rxData, rspData, rxSeen;
  logic [6:0] cmdAddr = 7'h00, busAddr;
  logic       txTake, rxValid, addrHit, readMode, stretchAbort, timeoutEvt2;
  logic       cmdReady, rspValid, rspNack, rspTimeout;
  int         errorCnt = 0, totalChecks = 0, hits, takes, aborts;
  smbtg_if busIf ();
  smbtg_if busIf2 ();
  smbtg_target #(.TIMEOUT_CYC(TO), .STRETCH_CYC(ST)) smbtg_target_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus(busIf.device),
    .addrStrapPin0(p0), .addrStrapPin1(p1), .addrStrapPin2(p2),
    .txValid(txValid), .txData(txData), .txTake(txTake), .rxValid(rxValid),
    .rxData(rxData), .addrHit(addrHit), .readMode(readMode), .busAddr(busAddr),
    .timeoutEvt(), .stretchAbort(stretchAbort));
  // Second end faces the bench, which breaks the clock-low rule on purpose
  smbtg_target #(.TIMEOUT_CYC(TO), .STRETCH_CYC(ST)) smbtg_target_inst2 (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus(busIf2.device),
    .addrStrapPin0(p0), .addrStrapPin1(p1), .addrStrapPin2(p2),
    .txValid(1'b0), .txData(8'h00), .txTake(), .rxValid(), .rxData(), .addrHit(),
    .readMode(), .busAddr(), .timeoutEvt(timeoutEvt2), .stretchAbort());
  smbtg_host #(.TIMEOUT_CYC(TO)) smbtg_host_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus(busIf.host), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .cmdRead(cmdRead), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack), .rspTimeout(rspTimeout));
  smbtg_chk #(.TIMEOUT_CYC(TO), .STRETCH_CYC(ST)) smbtg_chk_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .devSclO(busIf.devSclO), .devSclOeB(busIf.devSclOeB),
    .devSdaO(busIf.devSdaO), .devSdaOeB(busIf.devSdaOeB), .hostSclO(busIf.hostSclO),
    .hostSclOeB(busIf.hostSclOeB), .hostSdaO(busIf.hostSdaO),
    .hostSdaOeB(busIf.hostSdaOeB), .scl(busIf.scl), .sda(busIf.sda));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (addrHit === 1'b1) hits <= hits + 1;
    if (txTake === 1'b1) takes <= takes + 1;
    if (stretchAbort === 1'b1) aborts <= aborts + 1;
    if (rxValid === 1'b1) rxSeen <= rxData;
  end
  task automatic finalReport;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finalReport
  task automatic doReset;
    rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : doReset
  task automatic clr;
    hits = 0;
    takes = 0;
    aborts = 0;
    rxSeen = 8'h00;
  endtask : clr
  // Idle gap of 65 cycles after a stop must have passed before the next command
  task automatic runCmd(input logic [6:0] a, input logic rd, input logic [7:0] d);
    int n;
    n = 0;
    repeat (70) @(posedge sys_clk);
    `CHK("cmdReady", 1'b1, cmdReady)
    cmdValid <= 1'b1;
    cmdAddr  <= a;
    cmdRead  <= rd;
    cmdData  <= d;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    while (rspValid !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 40000) begin
        errorCnt++;
        $display("Error rspValid exp 1 got 0");
        finalReport();
      end
    end
  endtask : runCmd
  task automatic testStraps;
    for (int i = 0; i < 27; i++) begin
      p2 <= 2'(i / 9);
      p1 <= 2'((i / 3) % 3);
      p0 <= 2'(i % 3);
      doReset();
      `CHK("busAddr", EXP[i], busAddr)
    end
    p2 <= 2'h0;
    p1 <= 2'h2;
    p0 <= 2'h2;
    doReset();
    $display("test straps done");
  endtask : testStraps
  task automatic testWrite;
    clr();
    runCmd(7'h10, 1'b0, 8'hA5);
    `CHK("rspNack", 1'b0, rspNack)
    `CHK("rxData", 8'hA5, rxSeen)
    `CHK("readMode", 1'b0, readMode)
    `CHK("addrHit", 1, hits)
    $display("test write done");
  endtask : testWrite
  task automatic testNack;
    clr();
    runCmd(7'h11, 1'b0, 8'h5A);
    `CHK("rspNack", 1'b1, rspNack)
    `CHK("addrHit", 0, hits)
    $display("test nack done");
  endtask : testNack
  // Data arrives late, so the target stretches well inside its limit
  task automatic testRead;
    clr();
    fork
      runCmd(7'h10, 1'b1, 8'h00);
      begin
        for (int n = 0; n < 20000 && hits == 0; n++) @(posedge sys_clk);
        repeat (900) @(posedge sys_clk);
        txData  <= 8'h3C;
        txValid <= 1'b1;
        for (int n = 0; n < 3000 && takes == 0; n++) @(posedge sys_clk);
        txValid <= 1'b0;
      end
    join
    `CHK("rspData", 8'h3C, rspData)
    `CHK("readMode", 1'b1, readMode)
    `CHK("txTake", 1, takes)
    `CHK("stretchAbort", 0, aborts)
    $display("test read done");
  endtask : testRead
  task automatic testAbort;
    clr();
    runCmd(7'h10, 1'b1, 8'h00);
    `CHK("stretchAbort", 1, aborts)
    `CHK("rspData", 8'hFF, rspData)
    `CHK("rspTimeout", 1'b0, rspTimeout)
    $display("test abort done");
  endtask : testAbort
  task automatic testTimeout;
    int n;
    n = 0;
    busIf2.hostSdaOeB <= 1'b0;
    repeat (40) @(posedge sys_clk);
    busIf2.hostSclOeB <= 1'b0;
    while (timeoutEvt2 !== 1'b1 && n < TO + 100) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("timeoutEarly", 1'b1, n >= TO)
    `CHK("timeoutLate", 1'b1, n <= TO + 10)
    `CHK("devSdaOeB", 1'b1, busIf2.devSdaOeB)
    busIf2.hostSclOeB <= 1'b1;
    repeat (40) @(posedge sys_clk);
    busIf2.hostSdaOeB <= 1'b1;
    repeat (40) @(posedge sys_clk);
    $display("test timeout done");
  endtask : testTimeout
  initial begin
    busIf2.hostSclO = 1'b0;
    busIf2.hostSdaO = 1'b0;
    busIf2.hostSclOeB = 1'b1;
    busIf2.hostSdaOeB = 1'b1;
    doReset();
    testStraps();
    testWrite();
    testNack();
    testRead();
    testAbort();
    testWrite();
    testTimeout();
    finalReport();
  end
endmodule : smbus_target_addr_timeout_test
`default_nettype wire

// *** verilog/smbtg_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbtg_host #(
  parameter int BUS_CLOCK_RATE_HZ = smbtg_pkg::BUS_CLOCK_RATE_HZ,
  parameter int TIMEOUT_CYC       = smbtg_pkg::TIMEOUT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  smbtg_if.host           bus,
  input  wire logic       cmdValid,
  input  wire logic [6:0] cmdAddr,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdData,
  output logic            cmdReady,
  output logic            rspValid,
  output logic [7:0]      rspData,
  output logic            rspNack,
  output logic            rspTimeout
);
  localparam int HALF = smbtg_pkg::CLK_HZ / (2 * BUS_CLOCK_RATE_HZ);
  if (BUS_CLOCK_RATE_HZ < smbtg_pkg::BUS_CLOCK_RATE_MIN_HZ ||
      BUS_CLOCK_RATE_HZ > smbtg_pkg::BUS_CLOCK_RATE_MAX_HZ) begin : g_chkRate
    $error("Bus clock rate outside 10..400 kHz");
  end
  if (HALF > smbtg_pkg::HOST_STRETCH_CYC || HALF >= (1 << smbtg_pkg::HALF_W)) begin : g_chkHalf
    $error("Low phase exceeds host stretch limit");
  end
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << smbtg_pkg::CNT_W)) begin : g_chkTo
    $error("TIMEOUT_CYC out of counter range");
  end

  localparam logic [smbtg_pkg::HALF_W-1:0] H_LAST = smbtg_pkg::HALF_W'(HALF - 1);
  localparam logic [smbtg_pkg::HALF_W-1:0] H_MID  = smbtg_pkg::HALF_W'(HALF / 2);
  localparam logic [smbtg_pkg::HALF_W-1:0] G_LAST =
    smbtg_pkg::HALF_W'(smbtg_pkg::BUS_IDLE_GAP_CYC - 1);
  localparam logic [smbtg_pkg::CNT_W-1:0] TO_LAST = smbtg_pkg::CNT_W'(TIMEOUT_CYC - 1);

  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP1, H_STOP2, H_GAP}
    smbtg_hstate_t;

  logic sclM_r, sclS_r, sdaM_r, sdaS_r;
  always_ff @(posedge sys_clk) begin
    sclM_r <= bus.scl;
    sclS_r <= sclM_r;
    sdaM_r <= bus.sda;
    sdaS_r <= sdaM_r;
  end

  smbtg_hstate_t st_r, st_nxt;
  logic [smbtg_pkg::HALF_W-1:0] cnt_r, cnt_nxt;
  logic [smbtg_pkg::CNT_W-1:0]  lowCnt_r, lowCnt_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shReg_r, shReg_nxt, wrData_r, wrData_nxt, rspData_r, rspData_nxt;
  logic       byteIdx_r, byteIdx_nxt, rd_r, rd_nxt, nack_r, nack_nxt;
  logic       sclOeB_r, sclOeB_nxt, sdaOeB_r, sdaOeB_nxt, ready_r, ready_nxt;
  logic       rspV_r, rspV_nxt, rspTo_r, rspTo_nxt, rspN_r, rspN_nxt, zero_r;

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r + 1'b1;
    bitCnt_nxt  = bitCnt_r;
    shReg_nxt   = shReg_r;
    wrData_nxt  = wrData_r;
    rspData_nxt = rspData_r;
    byteIdx_nxt = byteIdx_r;
    rd_nxt      = rd_r;
    nack_nxt    = nack_r;
    sclOeB_nxt  = sclOeB_r;
    sdaOeB_nxt  = sdaOeB_r;
    ready_nxt   = ready_r;
    rspV_nxt    = 1'b0;
    rspTo_nxt   = rspTo_r;
    rspN_nxt    = rspN_r;
    lowCnt_nxt  = sclS_r ? '0 : (lowCnt_r == TO_LAST ? lowCnt_r : lowCnt_r + 1'b1);
    if (!sclS_r && lowCnt_r == TO_LAST - 1'b1 && st_r != H_GAP) begin
      // Abandon the transfer and free both lines
      st_nxt     = H_GAP;
      cnt_nxt    = '0;
      sclOeB_nxt = 1'b1;
      sdaOeB_nxt = 1'b1;
      rspV_nxt   = 1'b1;
      rspTo_nxt  = 1'b1;
      rspN_nxt   = 1'b1;
    end else begin
      case (st_r)
        H_IDLE: begin
          cnt_nxt = '0;
          if (cmdValid && ready_r) begin
            st_nxt      = H_START;
            ready_nxt   = 1'b0;
            shReg_nxt   = {cmdAddr, cmdRead};
            wrData_nxt  = cmdData;
            rd_nxt      = cmdRead;
            byteIdx_nxt = 1'b0;
            bitCnt_nxt  = smbtg_pkg::RST_BITS;
            sdaOeB_nxt  = 1'b0;
          end
        end
        H_START: if (cnt_r == H_LAST) begin
          st_nxt     = H_LOW;
          cnt_nxt    = '0;
          sclOeB_nxt = 1'b0;
        end
        H_LOW: begin
          if (cnt_r == H_MID) begin
            sdaOeB_nxt = (bitCnt_r == smbtg_pkg::ACK_SLOT) || (byteIdx_r && rd_r)
                         || shReg_r[7];
          end
          if (cnt_r == H_LAST) begin
            st_nxt     = H_HIGH;
            cnt_nxt    = '0;
            sclOeB_nxt = 1'b1;
          end
        end
        H_HIGH: begin
          // A target holding the clock low restarts the high-phase count from zero
          if (!sclS_r) begin
            cnt_nxt = '0;
          end else if (cnt_r == H_LAST) begin
            cnt_nxt    = '0;
            sclOeB_nxt = 1'b0;
            st_nxt     = H_LOW;
            if (bitCnt_r != smbtg_pkg::ACK_SLOT) begin
              shReg_nxt  = {shReg_r[6:0], sdaS_r};
              bitCnt_nxt = bitCnt_r + 4'h1;
            end else begin
              nack_nxt   = sdaS_r;
              bitCnt_nxt = smbtg_pkg::RST_BITS;
              if (byteIdx_r || sdaS_r) begin
                st_nxt = H_STOP1;
              end else begin
                byteIdx_nxt = 1'b1;
                shReg_nxt   = rd_r ? 8'hFF : wrData_r;
              end
            end
          end
        end
        H_STOP1: begin
          if (cnt_r == H_MID) begin
            sdaOeB_nxt = 1'b0;
          end
          if (cnt_r == H_LAST) begin
            st_nxt     = H_STOP2;
            cnt_nxt    = '0;
            sclOeB_nxt = 1'b1;
          end
        end
        H_STOP2: begin
          if (!sclS_r) begin
            cnt_nxt = '0;
          end else if (cnt_r == H_LAST) begin
            st_nxt      = H_GAP;
            cnt_nxt     = '0;
            sdaOeB_nxt  = 1'b1;
            rspV_nxt    = 1'b1;
            rspTo_nxt   = 1'b0;
            rspN_nxt    = byteIdx_r ? (nack_r && !rd_r) : 1'b1;
            rspData_nxt = shReg_r;
          end
        end
        H_GAP: if (cnt_r == G_LAST) begin
          st_nxt    = H_IDLE;
          ready_nxt = 1'b1;
        end
        default: st_nxt = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r      <= H_IDLE;
      cnt_r     <= '0;
      lowCnt_r  <= '0;
      bitCnt_r  <= smbtg_pkg::RST_BITS;
      shReg_r   <= 8'h00;
      wrData_r  <= 8'h00;
      rspData_r <= 8'h00;
      byteIdx_r <= 1'b0;
      rd_r      <= 1'b0;
      nack_r    <= 1'b0;
      sclOeB_r  <= 1'b1;
      sdaOeB_r  <= 1'b1;
      ready_r   <= 1'b1;
      rspV_r    <= 1'b0;
      rspTo_r   <= 1'b0;
      rspN_r    <= 1'b0;
      zero_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      lowCnt_r  <= lowCnt_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shReg_r   <= shReg_nxt;
      wrData_r  <= wrData_nxt;
      rspData_r <= rspData_nxt;
      byteIdx_r <= byteIdx_nxt;
      rd_r      <= rd_nxt;
      nack_r    <= nack_nxt;
      sclOeB_r  <= sclOeB_nxt;
      sdaOeB_r  <= sdaOeB_nxt;
      ready_r   <= ready_nxt;
      rspV_r    <= rspV_nxt;
      rspTo_r   <= rspTo_nxt;
      rspN_r    <= rspN_nxt;
      zero_r    <= 1'b0;
    end
  end

  assign bus.hostSclO   = zero_r;
  assign bus.hostSdaO   = zero_r;
  assign bus.hostSclOeB = sclOeB_r;
  assign bus.hostSdaOeB = sdaOeB_r;
  assign cmdReady       = ready_r;
  assign rspValid       = rspV_r;
  assign rspData        = rspData_r;
  assign rspNack        = rspN_r;
  assign rspTimeout     = rspTo_r;
endmodule : smbtg_host
`default_nettype wire

// *** verilog/smbtg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface smbtg_if;
  logic devSclO;
  logic devSclOeB;
  logic devSdaO;
  logic devSdaOeB;
  logic hostSclO;
  logic hostSclOeB;
  logic hostSdaO;
  logic hostSdaOeB;
  logic scl;
  logic sda;
  // Wired-AND with an implied pull-up
  assign scl = (devSclOeB | devSclO) & (hostSclOeB | hostSclO);
  assign sda = (devSdaOeB | devSdaO) & (hostSdaOeB | hostSdaO);
  modport device (input scl, sda, output devSclO, devSclOeB, devSdaO, devSdaOeB);
  modport host (input scl, sda, output hostSclO, hostSclOeB, hostSdaO, hostSdaOeB);
endinterface : smbtg_if
`default_nettype wire

// *** verilog/smbtg_pkg.sv ***
`default_nettype none
package smbtg_pkg;
  localparam int CLK_HZ           = 50_000_000;
  localparam int CLK_NS           = 20;
  localparam int CYC_PER_MS       = CLK_HZ / 1000;
  // Clock-low timeout window
  localparam int TIMEOUT_MIN_MS   = 25;
  localparam int TIMEOUT_MAX_MS   = 35;
  localparam int TIMEOUT_CYC      = TIMEOUT_MIN_MS * CYC_PER_MS + 1;
  localparam int TIMEOUT_MAX_CYC  = TIMEOUT_MAX_MS * CYC_PER_MS;
  // Cumulative stretch limits
  localparam int TGT_STRETCH_MS   = 25;
  localparam int TGT_STRETCH_CYC  = TGT_STRETCH_MS * CYC_PER_MS;
  localparam int HOST_STRETCH_MS  = 10;
  localparam int HOST_STRETCH_CYC = HOST_STRETCH_MS * CYC_PER_MS;
  // Bus idle gap between stop and next start
  localparam int BUS_IDLE_GAP_NS  = 1300;
  localparam int BUS_IDLE_GAP_CYC = (BUS_IDLE_GAP_NS + CLK_NS - 1) / CLK_NS;
  // Bus clock rate
  localparam int BUS_CLOCK_RATE_MIN_HZ = 10_000;
  localparam int BUS_CLOCK_RATE_MAX_HZ = 400_000;
  localparam int BUS_CLOCK_RATE_HZ     = 100_000;
  localparam int CNT_W            = 21;
  localparam int HALF_W           = 16;
  // Strap level codes
  localparam logic [1:0] LVL_OPEN = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] RST_BITS  = 4'h0;
  localparam logic [6:0] RST_ADDR  = 7'h00;
  // Index = 9*pin2 + 3*pin1 + pin0, each level open, low, high
  localparam logic [6:0] ADDR_TABLE [27] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h10,
    7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h53, 7'h53,
    7'h53, 7'h53, 7'h54, 7'h56, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5A};

  // Unused code 3 reads as open, the safe default for a floating strap
  function automatic logic [4:0] smbtg_lvl(input logic [1:0] lvl);
    smbtg_lvl = (lvl == 2'h3) ? 5'h00 : {3'h0, lvl};
  endfunction : smbtg_lvl

  function automatic logic [6:0] smbtg_decode(input logic [1:0] p2,
                                              input logic [1:0] p1,
                                              input logic [1:0] p0);
    logic [4:0] idx;
    idx = 5'(smbtg_lvl(p2) * 5'h09 + smbtg_lvl(p1) * 5'h03 + smbtg_lvl(p0));
    smbtg_decode = ADDR_TABLE[idx];
  endfunction : smbtg_decode
endpackage : smbtg_pkg
`default_nettype wire

// *** verilog/smbtg_target.sv ***
// Summary of operation
// - Three three-level straps select one of 27 table entries, 23 distinct addresses
// - Pin2 open decodes 40h-47h, then 10h
// - Pin2 low decodes 11h-17h, then 53h twice
// - Pin2 high decodes 53h,53h,54h,56h,56h,57h-5Ah
// - Clock low beyond 25 ms is a timeout
// - Reset transaction before 35 ms clock low
// - Target stretch per message capped 25 ms
// - Host stretch per byte at most 10 ms
// - Host clock between 10 and 400 kHz
// - Host waits 1.3 us after stop
`timescale 1ns/10ps
`default_nettype none
module smbtg_target #(
  parameter int TIMEOUT_CYC = smbtg_pkg::TIMEOUT_CYC,
  parameter int STRETCH_CYC = smbtg_pkg::TGT_STRETCH_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  smbtg_if.device         bus,
  input  wire logic [1:0] addrStrapPin0,
  input  wire logic [1:0] addrStrapPin1,
  input  wire logic [1:0] addrStrapPin2,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txTake,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            addrHit,
  output logic            readMode,
  output logic [6:0]      busAddr,
  output logic            timeoutEvt,
  output logic            stretchAbort
);
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << smbtg_pkg::CNT_W)) begin : g_chkTo
    $error("TIMEOUT_CYC out of counter range");
  end
  if (STRETCH_CYC < 2 || STRETCH_CYC >= (1 << smbtg_pkg::CNT_W)) begin : g_chkSt
    $error("STRETCH_CYC out of counter range");
  end

  localparam logic [smbtg_pkg::CNT_W-1:0] TO_LAST = smbtg_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [smbtg_pkg::CNT_W-1:0] ST_LAST = smbtg_pkg::CNT_W'(STRETCH_CYC - 1);

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_WRITE, D_READ, D_IGNORE} smbtg_phase_t;

  // Pin synchronisers; the second stage is the first one logic may read
  logic       sclM_r, sclS_r, sclP_r, sdaM_r, sdaS_r, sdaP_r;
  logic [5:0] strapM_r, strapS_r;
  always_ff @(posedge sys_clk) begin
    sclM_r   <= bus.scl;
    sclS_r   <= sclM_r;
    sclP_r   <= sclS_r;
    sdaM_r   <= bus.sda;
    sdaS_r   <= sdaM_r;
    sdaP_r   <= sdaS_r;
    strapM_r <= {addrStrapPin2, addrStrapPin1, addrStrapPin0};
    strapS_r <= strapM_r;
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise   = sclS_r & ~sclP_r;
  assign sclFall   = ~sclS_r & sclP_r;
  assign startCond = sclS_r & sclP_r & sdaP_r & ~sdaS_r;
  assign stopCond  = sclS_r & sclP_r & ~sdaP_r & sdaS_r;

  // Strap capture after reset release, once the synchroniser has filled
  logic [1:0] strapCnt_r, strapCnt_nxt;
  logic       strapDone_r, strapDone_nxt;
  logic [6:0] busAddr_r, busAddr_nxt;
  always_comb begin
    strapCnt_nxt  = strapCnt_r;
    strapDone_nxt = strapDone_r;
    busAddr_nxt   = busAddr_r;
    if (!strapDone_r) begin
      if (strapCnt_r == smbtg_pkg::STRAP_SETTLE) begin
        busAddr_nxt   = smbtg_pkg::smbtg_decode(strapS_r[5:4], strapS_r[3:2],
                                                strapS_r[1:0]);
        strapDone_nxt = 1'b1;
      end else begin
        strapCnt_nxt = strapCnt_r + 2'h1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strapCnt_r  <= 2'h0;
      strapDone_r <= 1'b0;
      busAddr_r   <= smbtg_pkg::RST_ADDR;
    end else begin
      strapCnt_r  <= strapCnt_nxt;
      strapDone_r <= strapDone_nxt;
      busAddr_r   <= busAddr_nxt;
    end
  end

  // Transaction engine
  smbtg_phase_t phase_r, phase_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shReg_r, shReg_nxt, rxData_r, rxData_nxt;
  logic       sdaOeB_r, sdaOeB_nxt, sclOeB_r, sclOeB_nxt;
  logic       rw_r, rw_nxt, hostAck_r, hostAck_nxt;
  logic       txTake_r, txTake_nxt, rxValid_r, rxValid_nxt, addrHit_r, addrHit_nxt;
  logic       toEvt_r, toEvt_nxt, stAbort_r, stAbort_nxt, zero_r;
  logic [smbtg_pkg::CNT_W-1:0] lowCnt_r, lowCnt_nxt, stCnt_r, stCnt_nxt;

  always_comb begin
    phase_nxt   = phase_r;
    bitCnt_nxt  = bitCnt_r;
    shReg_nxt   = shReg_r;
    rxData_nxt  = rxData_r;
    sdaOeB_nxt  = sdaOeB_r;
    sclOeB_nxt  = sclOeB_r;
    rw_nxt      = rw_r;
    hostAck_nxt = hostAck_r;
    txTake_nxt  = 1'b0;
    rxValid_nxt = 1'b0;
    addrHit_nxt = 1'b0;
    toEvt_nxt   = 1'b0;
    stAbort_nxt = 1'b0;
    lowCnt_nxt  = sclS_r ? '0 : (lowCnt_r == TO_LAST ? lowCnt_r : lowCnt_r + 1'b1);
    stCnt_nxt   = sclOeB_r ? stCnt_r : stCnt_r + 1'b1;
    if (!strapDone_r) begin
      phase_nxt = D_IDLE;
    end else if (!sclS_r && lowCnt_r == TO_LAST - 1'b1) begin
      // Reset at once on timeout, well inside the 35 ms ceiling
      phase_nxt  = D_IDLE;
      sdaOeB_nxt = 1'b1;
      sclOeB_nxt = 1'b1;
      toEvt_nxt  = 1'b1;
    end else if (!sclOeB_r && stCnt_r == ST_LAST) begin
      // Give up the message rather than hold the bus hostage
      phase_nxt   = D_IGNORE;
      sdaOeB_nxt  = 1'b1;
      sclOeB_nxt  = 1'b1;
      stAbort_nxt = 1'b1;
    end else if (stopCond) begin
      phase_nxt  = D_IDLE;
      sdaOeB_nxt = 1'b1;
      sclOeB_nxt = 1'b1;
    end else if (startCond) begin
      // One below zero, so the start's own clock fall lands on bit zero
      phase_nxt  = D_ADDR;
      bitCnt_nxt = smbtg_pkg::RST_BITS - 4'h1;
      sdaOeB_nxt = 1'b1;
      sclOeB_nxt = 1'b1;
      stCnt_nxt  = '0;
    end else if (!sclOeB_r) begin
      // Stretching until the user supplies a read byte
      if (txValid) begin
        shReg_nxt  = txData;
        sdaOeB_nxt = txData[7];
        txTake_nxt = 1'b1;
        sclOeB_nxt = 1'b1;
      end
    end else if (phase_r != D_IDLE && phase_r != D_IGNORE) begin
      if (sclRise) begin
        if (bitCnt_r < smbtg_pkg::ACK_SLOT && phase_r != D_READ) begin
          shReg_nxt = {shReg_r[6:0], sdaS_r};
        end else if (bitCnt_r == smbtg_pkg::ACK_SLOT && phase_r == D_READ) begin
          hostAck_nxt = ~sdaS_r;
        end
      end else if (sclFall) begin
        bitCnt_nxt = (bitCnt_r == smbtg_pkg::ACK_SLOT) ? smbtg_pkg::RST_BITS
                                                        : bitCnt_r + 4'h1;
        if (bitCnt_r == smbtg_pkg::LAST_BIT) begin
          case (phase_r)
            D_ADDR: begin
              if (shReg_r[7:1] == busAddr_r) begin
                sdaOeB_nxt  = 1'b0;
                rw_nxt      = shReg_r[0];
                addrHit_nxt = 1'b1;
              end else begin
                phase_nxt = D_IGNORE;
              end
            end
            D_WRITE: begin
              rxData_nxt  = shReg_r;
              rxValid_nxt = 1'b1;
              sdaOeB_nxt  = 1'b0;
            end
            default: sdaOeB_nxt = 1'b1;
          endcase
        end else if (bitCnt_r == smbtg_pkg::ACK_SLOT) begin
          sdaOeB_nxt = 1'b1;
          if ((phase_r == D_ADDR && rw_r) || (phase_r == D_READ && hostAck_r)) begin
            phase_nxt = D_READ;
            if (txValid) begin
              shReg_nxt  = txData;
              sdaOeB_nxt = txData[7];
              txTake_nxt = 1'b1;
            end else begin
              sclOeB_nxt = 1'b0;
            end
          end else if (phase_r == D_ADDR) begin
            phase_nxt = D_WRITE;
          end else if (phase_r == D_READ) begin
            phase_nxt = D_IGNORE;
          end
        end else if (phase_r == D_READ) begin
          shReg_nxt  = {shReg_r[6:0], 1'b0};
          sdaOeB_nxt = shReg_r[6];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_r   <= D_IDLE;
      bitCnt_r  <= smbtg_pkg::RST_BITS;
      shReg_r   <= 8'h00;
      rxData_r  <= 8'h00;
      sdaOeB_r  <= 1'b1;
      sclOeB_r  <= 1'b1;
      rw_r      <= 1'b0;
      hostAck_r <= 1'b0;
      txTake_r  <= 1'b0;
      rxValid_r <= 1'b0;
      addrHit_r <= 1'b0;
      toEvt_r   <= 1'b0;
      stAbort_r <= 1'b0;
      lowCnt_r  <= '0;
      stCnt_r   <= '0;
      zero_r    <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shReg_r   <= shReg_nxt;
      rxData_r  <= rxData_nxt;
      sdaOeB_r  <= sdaOeB_nxt;
      sclOeB_r  <= sclOeB_nxt;
      rw_r      <= rw_nxt;
      hostAck_r <= hostAck_nxt;
      txTake_r  <= txTake_nxt;
      rxValid_r <= rxValid_nxt;
      addrHit_r <= addrHit_nxt;
      toEvt_r   <= toEvt_nxt;
      stAbort_r <= stAbort_nxt;
      lowCnt_r  <= lowCnt_nxt;
      stCnt_r   <= stCnt_nxt;
      zero_r    <= 1'b0;
    end
  end

  assign bus.devSclO   = zero_r;
  assign bus.devSdaO   = zero_r;
  assign bus.devSclOeB = sclOeB_r;
  assign bus.devSdaOeB = sdaOeB_r;
  assign txTake        = txTake_r;
  assign rxValid       = rxValid_r;
  assign rxData        = rxData_r;
  assign addrHit       = addrHit_r;
  assign readMode      = rw_r;
  assign busAddr       = busAddr_r;
  assign timeoutEvt    = toEvt_r;
  assign stretchAbort  = stAbort_r;
endmodule : smbtg_target
`default_nettype wire
